/* rtl/phy_mgmt_pkg.sv */
package phy_mgmt_pkg;

    // ****************************************************************
    // register addresses within the management frame
    // ****************************************************************
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;
    localparam logic [4:0] REG_ID_LOW = 5'h03;
    localparam logic [4:0] REG_ADVERT = 5'h04;

    // ****************************************************************
    // basic status field positions
    // ****************************************************************
    localparam int STAT_TX_FULL = 14;
    localparam int STAT_TX_HALF = 13;
    localparam int STAT_T10_FULL = 12;
    localparam int STAT_T10_HALF = 11;
    localparam int STAT_PRE_SUPP = 6;
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_RFAULT = 4;
    localparam int STAT_AN_ABLE = 3;
    localparam int STAT_LINK = 2;
    localparam int STAT_JABBER = 1;
    localparam int STAT_EXT_CAP = 0;

    // ****************************************************************
    // advertisement field positions and reset values
    // ****************************************************************
    localparam int ADV_RFAULT = 13;
    localparam int ADV_TECH_LSB = 5;
    localparam int ADV_TECH_MSB = 12;
    localparam logic [7:0] ADV_TECH_RESET = 8'h2f;
    localparam logic ADV_RFAULT_RESET = 1'b0;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;

    // ****************************************************************
    // frame format and bit counts
    // ****************************************************************
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // frame receiver states, one-hot
    typedef enum logic [4:0]
    {
        ST_PREAMBLE = 5'b00001,
        ST_HEADER = 5'b00010,
        ST_TURN = 5'b00100,
        ST_READ = 5'b01000,
        ST_WRITE = 5'b10000
    } frame_state_type;

endpackage : phy_mgmt_pkg

/* rtl/mgmt_pin_sampler.sv */
`timescale 1ns/1ps
// ****************************************************************
// samples the management clock and data pins, flags clock rises
// ****************************************************************
module mgmt_pin_sampler
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdc_rise_o,
    output logic mdio_bit_o
);

    logic mdc_q; // previous clock pin level

    // rise flag and data bit are registered together so they stay aligned
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mdc_q <= 1'b1; // idle level, so a high pin at release is no rise
            mdc_rise_o <= 1'b0;
            mdio_bit_o <= 1'b1;
        end
        else
        begin
            mdc_q <= mdc_i;
            mdc_rise_o <= mdc_i & ~mdc_q;
            mdio_bit_o <= mdio_i;
        end
    end

endmodule : mgmt_pin_sampler

/* rtl/sticky_status_bit.sv */
`timescale 1ns/1ps
// ****************************************************************
// status bit that holds one level until the register is read
// ****************************************************************
module sticky_status_bit #(
    parameter logic HOLD_VALUE = 1'b0
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic cond_i,
    input wire logic read_i,
    output logic latched_o
);

    // a read reloads the live condition, so an event in the read cycle
    // is kept rather than lost
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            latched_o <= 1'b0;
        end
        else if (read_i)
        begin
            latched_o <= cond_i;
        end
        else if (HOLD_VALUE)
        begin
            latched_o <= latched_o | cond_i;
        end
        else
        begin
            latched_o <= latched_o & cond_i;
        end
    end

endmodule : sticky_status_bit

/* rtl/phy_status_ability_registers.sv */
`timescale 1ns/1ps
// Function
// - 100TX ability bits clear under ten-only strap
// - 10BASE-T ability bits always read one
// - preamble suppression bit zero, full preamble needed
// - negotiation complete bit follows engine, resets zero
// - remote fault bit follows detector, resets zero
// - negotiation ability bit always reads one
// - link bit resets zero and latches low
// - jabber bit resets zero and latches high
// - extended capability bit always reads one
// - reserved status bits read zero
// - two fixed identifier words, high then low
// - next page and reserved advertisement bits zero
// - advertised remote fault writable, resets zero
// - technology field writable, resets 00101111
// - selector field fixed at 00001
// - access only through serial management frames
module phy_status_ability_registers #(
    parameter logic [15:0] ID_HIGH_VALUE = 16'h0a5a, // arbitrary value
    parameter logic [15:0] ID_LOW_VALUE = 16'h5c01, // arbitrary value
    parameter logic [5:0] PREAMBLE_MIN = phy_mgmt_pkg::PREAMBLE_BITS
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_drive_n_o,
    input wire logic [4:0] phy_addr_i,
    input wire logic ten_only_advertise_strap_i,
    input wire logic an_complete_i,
    input wire logic remote_fault_i,
    input wire logic link_valid_i,
    input wire logic jabber_i,
    output logic [15:0] advert_page_o
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (PREAMBLE_MIN == 6'h00 || PREAMBLE_MIN == 6'h3f)
    begin : bad_preamble
        $error("preamble length must lie between 1 and 62");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    phy_mgmt_pkg::frame_state_type state; // frame receiver state
    logic mdc_rise; // one cycle per management clock rise
    logic mdio_bit; // data pin sampled with the rise
    logic [5:0] pre_count; // consecutive preamble ones, saturating
    logic [4:0] bit_count; // bit index inside the current field
    logic [11:0] hdr_shift; // header bits gathered so far
    logic [12:0] hdr_next; // header including the bit now sampled
    logic is_read; // frame carries the read opcode
    logic [4:0] reg_sel; // addressed register
    logic [15:0] data_shift; // read data out or write data in
    logic [15:0] wr_value; // completed write word
    logic strap_taken; // strap captured once after reset
    logic strap_q; // captured ten-only strap
    logic an_q; // registered negotiation complete
    logic rf_q; // registered remote fault
    logic link_latched; // latched-low link bit
    logic jabber_latched; // latched-high jabber bit
    logic adv_rfault; // advertised remote fault
    logic [7:0] adv_tech; // advertised technology field
    logic [15:0] status_word; // live basic status value
    logic [15:0] advert_word; // live advertisement value
    logic hdr_ok; // header legal and addressed to us
    logic read_start; // turnaround edge of a read: load and drive
    logic read_shift; // data edge of a read
    logic read_end; // edge after the last data bit
    logic write_commit; // last data bit of a write
    logic status_read; // basic status captured for a read

    // ****************************************************************
    // read mux
    // ****************************************************************
    // unmapped addresses answer zero so the frame still completes
    function automatic logic [15:0] read_word(input logic [4:0] sel,
        input logic [15:0] status, input logic [15:0] advert);
        logic [15:0] value;
        value = 16'h0000;
        unique case (sel)
            phy_mgmt_pkg::REG_BASIC_STATUS: value = status;
            phy_mgmt_pkg::REG_ID_HIGH: value = ID_HIGH_VALUE;
            phy_mgmt_pkg::REG_ID_LOW: value = ID_LOW_VALUE;
            phy_mgmt_pkg::REG_ADVERT: value = advert;
            default: value = 16'h0000;
        endcase
        return value;
    endfunction : read_word

    // ****************************************************************
    // pins and input capture
    // ****************************************************************
    mgmt_pin_sampler pins
    (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .mdc_rise_o(mdc_rise),
        .mdio_bit_o(mdio_bit)
    );

    // strap is taken in the first cycle after reset release, never under reset
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            strap_taken <= 1'b0;
            strap_q <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            strap_q <= ten_only_advertise_strap_i;
        end
    end

    // live conditions from the negotiation engine and fault detector
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            an_q <= 1'b0;
            rf_q <= 1'b0;
        end
        else
        begin
            an_q <= an_complete_i;
            rf_q <= remote_fault_i;
        end
    end

    // ****************************************************************
    // latched status bits
    // ****************************************************************
    sticky_status_bit #(.HOLD_VALUE(1'b0)) link_bit
    (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .cond_i(link_valid_i),
        .read_i(status_read),
        .latched_o(link_latched)
    );

    sticky_status_bit #(.HOLD_VALUE(1'b1)) jabber_bit
    (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .cond_i(jabber_i),
        .read_i(status_read),
        .latched_o(jabber_latched)
    );

    // ****************************************************************
    // register words
    // ****************************************************************
    always_comb
    begin
        status_word = 16'h0000;
        status_word[phy_mgmt_pkg::STAT_TX_FULL] = ~strap_q;
        status_word[phy_mgmt_pkg::STAT_TX_HALF] = ~strap_q;
        status_word[phy_mgmt_pkg::STAT_T10_FULL] = 1'b1;
        status_word[phy_mgmt_pkg::STAT_T10_HALF] = 1'b1;
        status_word[phy_mgmt_pkg::STAT_AN_DONE] = an_q;
        status_word[phy_mgmt_pkg::STAT_RFAULT] = rf_q;
        status_word[phy_mgmt_pkg::STAT_AN_ABLE] = 1'b1;
        status_word[phy_mgmt_pkg::STAT_LINK] = link_latched;
        status_word[phy_mgmt_pkg::STAT_JABBER] = jabber_latched;
        status_word[phy_mgmt_pkg::STAT_EXT_CAP] = 1'b1;
    end

    // next page and reserved bits stay zero, selector is fixed
    assign advert_word = {2'b00, adv_rfault, adv_tech, phy_mgmt_pkg::ADV_SELECTOR};

    // ****************************************************************
    // frame decode strobes
    // ****************************************************************
    assign hdr_next = {hdr_shift, mdio_bit};
    // start bit two must be one, opcode legal, address ours
    assign hdr_ok = hdr_next[12] && (hdr_next[9:5] == phy_addr_i)
        && (hdr_next[11:10] == phy_mgmt_pkg::OP_READ
        || hdr_next[11:10] == phy_mgmt_pkg::OP_WRITE);
    assign read_start = mdc_rise && state == phy_mgmt_pkg::ST_TURN && is_read;
    assign read_shift = mdc_rise && state == phy_mgmt_pkg::ST_READ
        && bit_count != phy_mgmt_pkg::DATA_BITS;
    assign read_end = mdc_rise && state == phy_mgmt_pkg::ST_READ
        && bit_count == phy_mgmt_pkg::DATA_BITS;
    assign write_commit = mdc_rise && state == phy_mgmt_pkg::ST_WRITE
        && bit_count == phy_mgmt_pkg::DATA_LAST;
    assign wr_value = {data_shift[14:0], mdio_bit};
    assign status_read = read_start && reg_sel == phy_mgmt_pkg::REG_BASIC_STATUS;

    // ****************************************************************
    // frame receiver
    // ****************************************************************
    // any header fault drops back to preamble hunting, which then needs
    // a full run of ones again; this costs a frame but never misreads one
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state <= phy_mgmt_pkg::ST_PREAMBLE;
            pre_count <= 6'h00;
            bit_count <= 5'h00;
            hdr_shift <= 12'h000;
            is_read <= 1'b0;
            reg_sel <= 5'h00;
        end
        else if (mdc_rise)
        begin
            unique case (state)
                phy_mgmt_pkg::ST_PREAMBLE:
                begin
                    bit_count <= 5'h00;
                    if (mdio_bit)
                    begin
                        // count ones, saturating at the minimum
                        if (pre_count != PREAMBLE_MIN)
                        begin
                            pre_count <= pre_count + 6'h01;
                        end
                    end
                    else if (pre_count == PREAMBLE_MIN)
                    begin
                        // first start bit after a full preamble
                        state <= phy_mgmt_pkg::ST_HEADER;
                    end
                    else
                    begin
                        // short preamble: frame is rejected
                        pre_count <= 6'h00;
                    end
                end
                phy_mgmt_pkg::ST_HEADER:
                begin
                    hdr_shift <= hdr_next[11:0];
                    bit_count <= bit_count + 5'h01;
                    pre_count <= 6'h00;
                    if (bit_count == phy_mgmt_pkg::HDR_LAST)
                    begin
                        bit_count <= 5'h00;
                        is_read <= hdr_next[11:10] == phy_mgmt_pkg::OP_READ;
                        reg_sel <= hdr_next[4:0];
                        // other addresses or bad framing are ignored
                        state <= hdr_ok ? phy_mgmt_pkg::ST_TURN
                            : phy_mgmt_pkg::ST_PREAMBLE;
                    end
                end
                phy_mgmt_pkg::ST_TURN:
                begin
                    bit_count <= bit_count + 5'h01;
                    if (is_read)
                    begin
                        bit_count <= 5'h00;
                        state <= phy_mgmt_pkg::ST_READ;
                    end
                    else if (bit_count == 5'h01)
                    begin
                        // writer's turnaround pair is not checked
                        bit_count <= 5'h00;
                        state <= phy_mgmt_pkg::ST_WRITE;
                    end
                end
                phy_mgmt_pkg::ST_READ:
                begin
                    bit_count <= bit_count + 5'h01;
                    if (read_end)
                    begin
                        state <= phy_mgmt_pkg::ST_PREAMBLE;
                    end
                end
                phy_mgmt_pkg::ST_WRITE:
                begin
                    bit_count <= bit_count + 5'h01;
                    if (write_commit)
                    begin
                        state <= phy_mgmt_pkg::ST_PREAMBLE;
                    end
                end
                default:
                begin
                    state <= phy_mgmt_pkg::ST_PREAMBLE;
                end
            endcase
        end
    end

    // data shifter: loads read data at turnaround, shifts on each edge
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            data_shift <= 16'h0000;
        end
        else if (read_start)
        begin
            data_shift <= read_word(reg_sel, status_word, advert_word);
        end
        else if (read_shift)
        begin
            data_shift <= {data_shift[14:0], 1'b0};
        end
        else if (mdc_rise && state == phy_mgmt_pkg::ST_WRITE)
        begin
            data_shift <= wr_value;
        end
    end

    // ****************************************************************
    // data pin driver
    // ****************************************************************
    // drive changes on the clock rise so the controller samples a
    // settled bit on the next rise
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mdio_o <= 1'b1;
            mdio_drive_n_o <= 1'b1;
        end
        else if (read_start)
        begin
            // second turnaround bit is a driven zero
            mdio_o <= 1'b0;
            mdio_drive_n_o <= 1'b0;
        end
        else if (read_shift)
        begin
            mdio_o <= data_shift[15];
        end
        else if (read_end)
        begin
            mdio_o <= 1'b1;
            mdio_drive_n_o <= 1'b1;
        end
    end

    // ****************************************************************
    // writable advertisement fields
    // ****************************************************************
    // read-only bits of the written word are dropped here
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            adv_rfault <= phy_mgmt_pkg::ADV_RFAULT_RESET;
            adv_tech <= phy_mgmt_pkg::ADV_TECH_RESET;
        end
        else if (write_commit && reg_sel == phy_mgmt_pkg::REG_ADVERT)
        begin
            adv_rfault <= wr_value[phy_mgmt_pkg::ADV_RFAULT];
            adv_tech <= wr_value[phy_mgmt_pkg::ADV_TECH_MSB:phy_mgmt_pkg::ADV_TECH_LSB];
        end
    end

    // page handed to the negotiation engine
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            advert_page_o <= {2'b00, phy_mgmt_pkg::ADV_RFAULT_RESET,
                phy_mgmt_pkg::ADV_TECH_RESET, phy_mgmt_pkg::ADV_SELECTOR};
        end
        else
        begin
            advert_page_o <= advert_word;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    strap_ability_a: assert property ($rose(strap_taken) |-> status_word[14:13]
        == {2{~$past(ten_only_advertise_strap_i)}})
        else $error("100TX ability bits disagree with strap");
    ten_ability_a: assert property (status_read |=> data_shift[12:11] == 2'b11)
        else $error("10BASE-T ability bits not read as one");
    short_preamble_a: assert property (state == phy_mgmt_pkg::ST_PREAMBLE && mdc_rise
        && !mdio_bit && pre_count != PREAMBLE_MIN |=> state == phy_mgmt_pkg::ST_PREAMBLE)
        else $error("frame accepted after short preamble");
    an_done_a: assert property (an_complete_i |=> status_word[5])
        else $error("negotiation complete not reported");
    remote_fault_a: assert property (remote_fault_i |=> status_word[4])
        else $error("remote fault not reported");
    fixed_status_a: assert property (status_word[15] == 1'b0 && status_word[10:6] == 5'h00
        && status_word[3] && status_word[0])
        else $error("fixed status bits wrong");
    link_low_a: assert property (!link_valid_i |=> !link_latched)
        else $error("link loss not latched");
    link_hold_a: assert property (!link_latched && !status_read |=> !link_latched)
        else $error("latched link low released without read");
    jabber_high_a: assert property (jabber_i |=> jabber_latched)
        else $error("jabber not latched");
    id_read_a: assert property (read_start && reg_sel == phy_mgmt_pkg::REG_ID_HIGH
        |=> data_shift == ID_HIGH_VALUE)
        else $error("identifier high word wrong");
    advert_fixed_a: assert property (advert_page_o[15:14] == 2'b00
        && advert_page_o[4:0] == phy_mgmt_pkg::ADV_SELECTOR)
        else $error("fixed advertisement bits wrong");
    advert_write_a: assert property (write_commit && reg_sel == phy_mgmt_pkg::REG_ADVERT
        |=> ##1 advert_page_o[13:5] == $past(wr_value[13:5], 2))
        else $error("advertisement write not applied");
    read_turn_a: assert property (read_start |=> !mdio_drive_n_o && !mdio_o ##1 !mdio_drive_n_o)
        else $error("turnaround zero not driven");

    status_read_c: cover property (status_read);
    advert_write_c: cover property (write_commit && reg_sel == phy_mgmt_pkg::REG_ADVERT);
    link_recover_c: cover property (!link_latched && link_valid_i ##1 status_read);

endmodule : phy_status_ability_registers

/* verif/mgmt_controller_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// controller model: drives management frames, releases for reads
// ****************************************************************
module mgmt_controller_model
(
    input wire logic core_clk_i,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    // idle: clock high, data released so the pull-up holds the line
    initial
    begin
        mdc_o = 1'b1;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // one bit: four core cycles low, then high; sampled as the clock rises
    task automatic clk_bit(input logic oe, input logic b, output logic s);
        @(posedge core_clk_i);
        #1 mdc_o = 1'b0;
        mdio_oe_o = oe;
        mdio_o = b;
        repeat (4) @(posedge core_clk_i);
        #1 s = mdio_i;
        mdc_o = 1'b1;
        repeat (3) @(posedge core_clk_i);
    endtask : clk_bit
    // whole frame; preamble length is an argument so a short one can be tried
    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, pa, ra};
        rd = 16'h0000;
        for (int i = 0; i < pre; i++) clk_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        // writer sends turnaround 1,0 then data; reader lets go and samples
        for (int i = 17; i >= 0; i--)
        begin
            clk_bit(op == phy_mgmt_pkg::OP_WRITE, (i > 15) ? (i == 17) : wd[i], s);
            if (i < 16) rd[i] = s;
        end
        // one released bit closes the frame
        clk_bit(1'b0, 1'b1, s);
    endtask : frame
endmodule : mgmt_controller_model

/* verif/tb_phy_status_ability_registers.sv */
`timescale 1ns/1ps
module tb_phy_status_ability_registers;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam logic [15:0] ID_H = 16'h0b1e; // arbitrary value
    localparam logic [15:0] ID_L = 16'h6d02; // arbitrary value
    localparam logic [4:0] PA = 5'h05; // our management address
    localparam logic [1:0] RD = phy_mgmt_pkg::OP_READ;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic mdc, m_out, m_oe, d_out, d_drive_n;
    logic strap = 1'b0, an = 1'b0, rf = 1'b0, link = 1'b1, jab = 1'b0;
    logic [15:0] adv, rd;
    int bad_count = 0;
    int samples_checked = 0;
    // wired line: pull-up wins when nobody drives
    wire mdio_line = !d_drive_n ? d_out : (m_oe ? m_out : 1'b1);
    phy_status_ability_registers #(.ID_HIGH_VALUE(ID_H), .ID_LOW_VALUE(ID_L))
        phy_status_ability_registers_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(d_out), .mdio_drive_n_o(d_drive_n),
        .phy_addr_i(PA), .ten_only_advertise_strap_i(strap), .an_complete_i(an),
        .remote_fault_i(rf), .link_valid_i(link), .jabber_i(jab), .advert_page_o(adv));
    mgmt_controller_model mgmt_controller_model_i (.core_clk_i(core_clk_i),
        .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(m_out), .mdio_oe_o(m_oe));
    // 250 MHz core clock
    initial forever #2 core_clk_i = ~core_clk_i;
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // strap must settle before release since it is captured once
    task automatic do_reset(input logic s);
        @(posedge core_clk_i);
        #1 reset_i = 1'b1;
        strap = s;
        repeat (6) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask : do_reset
    task automatic rd_reg(input logic [4:0] ra);
        mgmt_controller_model_i.frame(32, RD, PA, ra, 16'h0000, rd);
    endtask : rd_reg
    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] d;
        mgmt_controller_model_i.frame(32, phy_mgmt_pkg::OP_WRITE, PA, ra, wd, d);
    endtask : wr_reg
    // expected status word from conditions, latched values and strap
    function automatic logic [15:0] st(input logic a, r, l, j, s);
        st = 16'h1809 | {1'b0, ~s, ~s, 7'h00, a, r, 1'b0, l, j, 1'b0};
    endfunction : st
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        do_reset(1'b0);
        check("advert reset", adv, 16'h05e1);
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("status after reset", rd, st(0, 0, 0, 0, 0));
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("status live", rd, st(0, 0, 1, 0, 0));
        // brief link loss and jabber burst must both be caught
        @(posedge core_clk_i);
        #1 {an, rf, link, jab} = 4'b1101;
        repeat (3) @(posedge core_clk_i);
        #1 {link, jab} = 2'b10;
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("status events", rd, st(1, 1, 0, 1, 0));
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("status released", rd, st(1, 1, 1, 0, 0));
        rd_reg(phy_mgmt_pkg::REG_ID_HIGH);
        check("id high", rd, ID_H);
        rd_reg(phy_mgmt_pkg::REG_ID_LOW);
        check("id low", rd, ID_L);
        wr_reg(phy_mgmt_pkg::REG_ADVERT, 16'hffff);
        check("advert page", adv, 16'h3fe1);
        rd_reg(phy_mgmt_pkg::REG_ADVERT);
        check("advert read", rd, 16'h3fe1);
        wr_reg(phy_mgmt_pkg::REG_ADVERT, 16'h0000);
        check("advert cleared", adv, 16'h0001);
        wr_reg(phy_mgmt_pkg::REG_BASIC_STATUS, 16'h0000);
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("status unwritable", rd, st(1, 1, 1, 0, 0));
        // the closing released bit of the last frame is one more preamble one
        mgmt_controller_model_i.frame(30, RD, PA, 5'h02, 16'h0000, rd);
        check("short preamble", rd, 16'hffff);
        mgmt_controller_model_i.frame(32, RD, PA ^ 5'h01, 5'h02, 16'h0000, rd);
        check("other address", rd, 16'hffff);
        rd_reg(5'h05);
        check("unmapped read", rd, 16'h0000);
        check("line released", {15'h0000, d_drive_n}, 16'h0001);
        do_reset(1'b1);
        rd_reg(phy_mgmt_pkg::REG_BASIC_STATUS);
        check("ten only strap", rd, st(1, 1, 0, 0, 1));
        tally_and_finish();
    end
    // watchdog: the frames above need about 30 us
    initial
    begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_phy_status_ability_registers
